// File: inc/gsw_pkg.sv
// Constants, types and helpers of the gain set switching block
// How it works
// - Low config digit 0 disables automatic switching, 2 enables it.
// - Automatic switching runs only in position control.
// - Set 1: speed gain, integral time, position gain, torque filter, friction gain.
// - Set 2: the second copies of those five values.
// - Condition A true: go from set 1 to set 2, wait up, ramp up.
// - Condition A false: go from set 2 to set 1, wait down, ramp down.
// - Hold present gains for the waiting time before any ramp starts.
// - Ramp moves every gain linearly to its new value over the switching time.
// - Second digit picks condition A among six codes 0 to 5.
// - Outside position control codes 0,2,4 fix set 1; 1,3,5 fix set 2.
// - Model following gain and correction never switch.
// - Switching ignores whether the speed loop is PI or I-P.
// - Wait and switching times run 0 to 65535 ms, default 0.
package gsw_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NGAIN = 5;
	localparam int NREG = 18;
	localparam int GW = 16;
	typedef logic [NGAIN-1:0][GW-1:0] gsw_gains_t;
	// Register indices, byte address is four times the index
	localparam logic [13:0] IDX_CFG = 14'h2139;
	localparam logic [13:0] IDX_STATUS = 14'h21F0;
	localparam logic [13:0] REG_IDX [NREG] = '{14'h2139,
		14'h2100, 14'h2101, 14'h2102, 14'h2401, 14'h2121,
		14'h2104, 14'h2105, 14'h2106, 14'h2412, 14'h2122,
		14'h2135, 14'h2136, 14'h2131, 14'h2132,
		14'h2141, 14'h2142, 14'h210B};
	// Slot of each register in the storage array
	localparam int SL_CFG = 0;
	localparam int SL_A = 1;
	localparam int SL_B = 6;
	localparam int SL_WAIT_UP = 11;
	localparam int SL_WAIT_DN = 12;
	localparam int SL_RAMP_UP = 13;
	localparam int SL_RAMP_DN = 14;
	localparam int SL_MF_GAIN = 15;
	localparam int SL_MF_CORR = 16;
	localparam int SL_STRUCT = 17;
	localparam logic [15:0] MF_GAIN_RST = 16'h0000;
	localparam logic [15:0] MF_CORR_RST = 16'h0000;
	localparam logic [15:0] REG_RST [NREG] = '{16'h0000,
		16'h0190, 16'h07D0, 16'h0190, 16'h0064, 16'h0064,
		16'h0190, 16'h07D0, 16'h0190, 16'h0064, 16'h0064,
		16'h0000, 16'h0000, 16'h0000, 16'h0000,
		MF_GAIN_RST, MF_CORR_RST, 16'h0000};
	localparam gsw_gains_t GAINS_RST = {16'h0064, 16'h0064, 16'h0190, 16'h07D0, 16'h0190};
	// Config digits
	localparam int DIG_W = 4;
	localparam int CFG_AUTO_LSB = 0;
	localparam int CFG_COND_LSB = 4;
	localparam logic [3:0] AUTO_OFF = 4'h0;
	localparam logic [3:0] AUTO_RSVD = 4'h1;
	localparam logic [3:0] AUTO_ON = 4'h2;
	localparam logic [3:0] COND_DONE_ON = 4'h0;
	localparam logic [3:0] COND_DONE_OFF = 4'h1;
	localparam logic [3:0] COND_NEAR_ON = 4'h2;
	localparam logic [3:0] COND_NEAR_OFF = 4'h3;
	localparam logic [3:0] COND_REF_IDLE = 4'h4;
	localparam logic [3:0] COND_REF_IN = 4'h5;
	// Control modes
	localparam logic [1:0] MODE_POS = 2'h0;
	localparam logic [1:0] MODE_SPD = 2'h1;
	localparam logic [1:0] MODE_TRQ = 2'h2;
	// Status bits
	localparam int STAT_SET2 = 0;
	localparam int STAT_WAIT = 1;
	localparam int STAT_RAMP = 2;
	typedef enum logic [5:0] {
		ST_SET1 = 6'h01,
		ST_WAIT_UP = 6'h02,
		ST_RAMP_UP = 6'h04,
		ST_SET2 = 6'h08,
		ST_WAIT_DN = 6'h10,
		ST_RAMP_DN = 6'h20
	} gsw_state_t;

	// Linear blend a to b at num/den, b once num reaches den
	function automatic logic [15:0] gsw_interp(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] num, input logic [15:0] den);
		logic signed [33:0] diff;
		logic signed [33:0] step;
		if (den == 16'h0 || num >= den)
			return b; // Zero ramp or end: no divide by zero
		diff = $signed({18'h0, b}) - $signed({18'h0, a});
		step = (diff * $signed({18'h0, num})) / $signed({18'h0, den});
		return 16'(step + $signed({18'h0, a}));
	endfunction : gsw_interp

	// Byte lane merge of a bus write into a 16-bit register
	function automatic logic [15:0] gsw_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = wd[7:0];
		if (sel[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction : gsw_merge
endpackage : gsw_pkg

// File: inc/gsw_ramp_if.sv
// Link between the switching sequencer and the gain blender
`timescale 1ns/100ps
interface gsw_ramp_if;
	gsw_pkg::gsw_gains_t set_a;
	gsw_pkg::gsw_gains_t set_b;
	gsw_pkg::gsw_gains_t gains;
	logic sel2;
	logic ramp;
	logic up;
	logic [15:0] num;
	logic [15:0] den;
	modport ctl (output set_a, set_b, sel2, ramp, up, num, den, input gains);
	modport dp (input set_a, set_b, sel2, ramp, up, num, den, output gains);
endinterface : gsw_ramp_if

// File: rtl/gsw_ramp.sv
// Gain blender: steady set or linear ramp between sets
`timescale 1ns/100ps
module gsw_ramp import gsw_pkg::*; (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Sync reset, high
	gsw_ramp_if.dp rif // Sets in, gains out
);
	gsw_gains_t gains;
	gsw_gains_t next_gains;

	// Pick or blend every gain
	always_comb begin
		for (int i = 0; i < NGAIN; i++) begin
			if (!rif.ramp)
				next_gains[i] = rif.sel2 ? rif.set_b[i] : rif.set_a[i];
			else if (rif.up)
				next_gains[i] = gsw_interp(rif.set_a[i], rif.set_b[i], rif.num, rif.den);
			else
				next_gains[i] = gsw_interp(rif.set_b[i], rif.set_a[i], rif.num, rif.den);
		end
	end

	// Gain output flops
	always_ff @(posedge clk_i) begin
		gains <= rst_i ? GAINS_RST : next_gains;
	end

	assign rif.gains = gains;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_steady_a;
		!rif.ramp && !rif.sel2 |=> gains == $past(rif.set_a);
	endproperty
	a_steady_a: assert property (p_steady_a) else $error("set 1 not applied");

	property p_steady_b;
		!rif.ramp && rif.sel2 |=> gains == $past(rif.set_b);
	endproperty
	a_steady_b: assert property (p_steady_b) else $error("set 2 not applied");

	property p_ramp_end;
		rif.ramp && rif.num >= rif.den |=>
			gains == ($past(rif.up) ? $past(rif.set_b) : $past(rif.set_a));
	endproperty
	a_ramp_end: assert property (p_ramp_end) else $error("ramp misses target");

	property p_ramp_start;
		rif.ramp && rif.num == 16'h0 && rif.den != 16'h0 |=>
			gains == ($past(rif.up) ? $past(rif.set_a) : $past(rif.set_b));
	endproperty
	a_ramp_start: assert property (p_ramp_start) else $error("ramp jumps at start");
endmodule : gsw_ramp

// File: rtl/gsw_gain_switch.sv
// Gain set switching: registers, condition A, sequencer
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
module gsw_gain_switch import gsw_pkg::*; #(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	input wire logic clk_i, // Clock, 200 MHz
	input wire logic rst_i, // Sync reset, high
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	input wire logic we_i, // Wishbone write
	input wire logic [15:0] adr_i, // Byte address
	input wire logic [3:0] sel_i, // Byte enables
	input wire logic [31:0] dat_i, // Write data
	output logic [31:0] dat_o, // Read data
	output logic ack_o, // Wishbone ack
	input wire logic [1:0] ctrl_mode_i, // Control method
	input wire logic positioning_done_i, // Positioning done
	input wire logic near_i, // Near position
	input wire logic ref_filter_zero_i, // Ref filter out is 0
	input wire logic ref_input_i, // Position ref present
	output logic [15:0] speed_loop_gain_o, // Active speed gain
	output logic [15:0] speed_integral_time_o, // Active integral time
	output logic [15:0] position_loop_gain_o, // Active position gain
	output logic [15:0] torque_filter_time_o, // Active torque filter
	output logic [15:0] friction_comp_gain_o, // Active friction gain
	output logic [15:0] mf_gain_o, // Model following gain
	output logic [15:0] mf_corr_o, // Model following corr.
	output logic [15:0] speed_loop_structure_o, // PI or I-P select
	output logic gain_set2_o, // Set 2 active
	output logic gain_switching_o // Wait or ramp busy
);
	logic [15:0] regs [NREG];
	logic [15:0] next_regs [NREG];
	logic ack;
	logic next_ack;
	logic [31:0] rdat;
	logic [31:0] next_rdat;
	gsw_state_t state;
	gsw_state_t next_state;
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic [15:0] ms_cnt;
	logic [15:0] next_ms_cnt;
	logic mon_set2;
	logic next_mon_set2;
	logic mon_busy;
	logic next_mon_busy;
	logic req;
	logic hit;
	logic [13:0] idx;
	logic [3:0] auto_dig;
	logic [3:0] cond_code;
	logic cond_a;
	logic auto_en;
	logic fixed_set2;
	logic tick;
	logic [15:0] status;
	gsw_ramp_if rif ();

	assign req = cyc_i && stb_i && !ack;
	assign idx = adr_i[15:2];
	assign auto_dig = regs[SL_CFG][CFG_AUTO_LSB +: DIG_W];
	assign cond_code = regs[SL_CFG][CFG_COND_LSB +: DIG_W];

	// Condition A selection
	always_comb begin
		unique case (cond_code)
			COND_DONE_ON: cond_a = positioning_done_i;
			COND_DONE_OFF: cond_a = !positioning_done_i;
			COND_NEAR_ON: cond_a = near_i;
			COND_NEAR_OFF: cond_a = !near_i;
			COND_REF_IDLE: cond_a = ref_filter_zero_i && !ref_input_i;
			COND_REF_IN: cond_a = ref_input_i;
			default: cond_a = 1'b0;
		endcase
	end

	// Reserved code 1 and unknown codes act as switching off
	assign auto_en = (ctrl_mode_i == MODE_POS) && (auto_dig == AUTO_ON);
	// Odd condition codes 1, 3, 5 pin set 2 outside position control
	assign fixed_set2 = (ctrl_mode_i != MODE_POS) && cond_code[0]
		&& (cond_code <= COND_REF_IN);
	assign tick = tick_cnt == 32'(MS_CYCLES_P - 1);

	// Status word
	always_comb begin
		status = 16'h0;
		status[STAT_SET2] = mon_set2;
		status[STAT_WAIT] = (state == ST_WAIT_UP) || (state == ST_WAIT_DN);
		status[STAT_RAMP] = (state == ST_RAMP_UP) || (state == ST_RAMP_DN);
	end

	// Register file and bus answer, next values
	always_comb begin
		next_regs = regs;
		next_ack = req;
		next_rdat = 32'h0;
		hit = 1'b0;
		for (int s = 0; s < NREG; s++) begin
			if (REG_IDX[s] == idx) begin
				hit = 1'b1;
				next_rdat = {16'h0, regs[s]};
				if (req && we_i)
					next_regs[s] = gsw_merge(regs[s], dat_i, sel_i);
			end
		end
		if (!hit && idx == IDX_STATUS)
			next_rdat = {16'h0, status};
		if (!req || we_i)
			next_rdat = 32'h0;
	end

	// Register file and bus answer flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			regs <= REG_RST;
			ack <= 1'b0;
			rdat <= 32'h0;
		end else begin
			regs <= next_regs;
			ack <= next_ack;
			rdat <= next_rdat;
		end
	end

	assign ack_o = ack;
	assign dat_o = rdat;

	// Switching sequencer, next values
	always_comb begin
		next_state = state;
		next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
		next_ms_cnt = (tick && ms_cnt != 16'hFFFF) ? ms_cnt + 16'h1 : ms_cnt;
		unique case (state)
			ST_SET1: if (cond_a) begin
				next_state = ST_WAIT_UP;
			end
			ST_WAIT_UP: if (!cond_a) begin
				next_state = ST_SET1;
			end else if (ms_cnt >= regs[SL_WAIT_UP]) begin
				next_state = ST_RAMP_UP;
			end
			ST_RAMP_UP: if (ms_cnt >= regs[SL_RAMP_UP]) begin
				next_state = ST_SET2;
			end
			ST_SET2: if (!cond_a) begin
				next_state = ST_WAIT_DN;
			end
			ST_WAIT_DN: if (cond_a) begin
				next_state = ST_SET2;
			end else if (ms_cnt >= regs[SL_WAIT_DN]) begin
				next_state = ST_RAMP_DN;
			end
			ST_RAMP_DN: if (ms_cnt >= regs[SL_RAMP_DN]) begin
				next_state = ST_SET1;
			end
			default: next_state = ST_SET1;
		endcase
		// Without automatic switching the set is fixed at once
		if (!auto_en)
			next_state = fixed_set2 ? ST_SET2 : ST_SET1;
		// Every state starts its millisecond count afresh
		if (next_state != state) begin
			next_tick_cnt = 32'h0;
			next_ms_cnt = 16'h0;
		end
		next_mon_set2 = (next_state == ST_RAMP_UP) || (next_state == ST_SET2)
			|| (next_state == ST_WAIT_DN);
		next_mon_busy = !((next_state == ST_SET1) || (next_state == ST_SET2));
	end

	// Switching sequencer flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_SET1;
			tick_cnt <= 32'h0;
			ms_cnt <= 16'h0;
			mon_set2 <= 1'b0;
			mon_busy <= 1'b0;
		end else begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			ms_cnt <= next_ms_cnt;
			mon_set2 <= next_mon_set2;
			mon_busy <= next_mon_busy;
		end
	end

	// Drive the blender; loop structure plays no part here
	assign rif.set_a = {regs[SL_A+4], regs[SL_A+3], regs[SL_A+2], regs[SL_A+1], regs[SL_A]};
	assign rif.set_b = {regs[SL_B+4], regs[SL_B+3], regs[SL_B+2], regs[SL_B+1], regs[SL_B]};
	assign rif.sel2 = (state == ST_SET2) || (state == ST_WAIT_DN);
	assign rif.ramp = (state == ST_RAMP_UP) || (state == ST_RAMP_DN);
	assign rif.up = state == ST_RAMP_UP;
	assign rif.num = ms_cnt;
	assign rif.den = rif.up ? regs[SL_RAMP_UP] : regs[SL_RAMP_DN];

	gsw_ramp u_ramp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rif(rif.dp)
	);

	// Outputs
	assign speed_loop_gain_o = rif.gains[0];
	assign speed_integral_time_o = rif.gains[1];
	assign position_loop_gain_o = rif.gains[2];
	assign torque_filter_time_o = rif.gains[3];
	assign friction_comp_gain_o = rif.gains[4];
	assign mf_gain_o = regs[SL_MF_GAIN];
	assign mf_corr_o = regs[SL_MF_CORR];
	assign speed_loop_structure_o = regs[SL_STRUCT];
	assign gain_set2_o = mon_set2;
	assign gain_switching_o = mon_busy;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wb_req;
		cyc_i && stb_i && !ack;
	endsequence

	property p_wb_ack;
		s_wb_req |=> ack ##1 !ack;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle");

	property p_no_auto;
		ctrl_mode_i != MODE_POS |=> state == ST_SET1 || state == ST_SET2;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("switching outside position");

	property p_auto_off;
		ctrl_mode_i == MODE_POS && auto_dig != AUTO_ON |=> state == ST_SET1;
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("set 1 not kept");

	property p_fixed;
		ctrl_mode_i != MODE_POS && (cond_code == COND_DONE_OFF || cond_code == COND_REF_IN)
			|=> state == ST_SET2;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed set 2 missing");

	property p_up_start;
		state == ST_SET1 && auto_en && cond_a |=> state == ST_WAIT_UP;
	endproperty
	a_up_start: assert property (p_up_start) else $error("no wait on condition");

	property p_dn_start;
		state == ST_SET2 && auto_en && !cond_a |=> state == ST_WAIT_DN;
	endproperty
	a_dn_start: assert property (p_dn_start) else $error("no wait on release");

	property p_hold_wait;
		state == ST_WAIT_UP && auto_en && cond_a && ms_cnt < regs[SL_WAIT_UP]
			|=> state == ST_WAIT_UP;
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("wait cut short");

	property p_ramp_done;
		state == ST_RAMP_UP && auto_en && ms_cnt >= regs[SL_RAMP_UP]
			|=> state == ST_SET2 ##1 position_loop_gain_o == $past(regs[SL_B+2]);
	endproperty
	a_ramp_done: assert property (p_ramp_done) else $error("ramp end wrong");

	property p_ms_step;
		state == ST_WAIT_UP && tick && $stable(state) && ms_cnt != 16'hFFFF
			&& auto_en && cond_a && ms_cnt < regs[SL_WAIT_UP]
			|=> ms_cnt == $past(ms_cnt) + 16'h1;
	endproperty
	a_ms_step: assert property (p_ms_step) else $error("ms count slip");

	property p_hold_wait_dn;
		state == ST_WAIT_DN && auto_en && !cond_a && ms_cnt < regs[SL_WAIT_DN]
			|=> state == ST_WAIT_DN;
	endproperty
	a_hold_wait_dn: assert property (p_hold_wait_dn) else $error("wait down cut short");

	// Wait ends: ramp begins with monitors updated
	sequence s_wait_up_end;
		state == ST_WAIT_UP && auto_en && cond_a && ms_cnt >= regs[SL_WAIT_UP];
	endsequence

	property p_ramp_up_start;
		s_wait_up_end |=> state == ST_RAMP_UP && gain_set2_o && gain_switching_o;
	endproperty
	a_ramp_up_start: assert property (p_ramp_up_start) else $error("ramp up not begun");

	sequence s_wait_dn_end;
		state == ST_WAIT_DN && auto_en && !cond_a && ms_cnt >= regs[SL_WAIT_DN];
	endsequence

	property p_ramp_dn_start;
		s_wait_dn_end |=> state == ST_RAMP_DN && !gain_set2_o && gain_switching_o;
	endproperty
	a_ramp_dn_start: assert property (p_ramp_dn_start) else $error("ramp down not begun");

	property p_ramp_dn_done;
		state == ST_RAMP_DN && auto_en && ms_cnt >= regs[SL_RAMP_DN]
			|=> state == ST_SET1 ##1 position_loop_gain_o == $past(regs[SL_A+2]);
	endproperty
	a_ramp_dn_done: assert property (p_ramp_dn_done) else $error("ramp down end wrong");

	// Model following values move only on a bus write
	property p_mf_fixed;
		!(req && we_i) |=> $stable(mf_gain_o) && $stable(mf_corr_o);
	endproperty
	a_mf_fixed: assert property (p_mf_fixed) else $error("model following value moved");
endmodule : gsw_gain_switch

// File: tb/gsw_host_model.sv
// Host controller model: reference traffic and motion status
`timescale 1ns/100ps
module gsw_host_model (
	input wire logic clk_i, // Clock
	input wire logic move_i, // Host sends references
	output logic ref_o = 1'b0, // Reference input present
	output logic fzero_o = 1'b1, // Filter output zero
	output logic done_o = 1'b1, // Positioning done
	output logic near_o = 1'b1 // Near position
);
	// Status follows motion one edge later
	always @(posedge clk_i) begin
		ref_o <= move_i;
		fzero_o <= !move_i;
		done_o <= !move_i;
		near_o <= !move_i;
	end
endmodule : gsw_host_model

// File: tb/test_servo_gain_set_switching.sv
// Self-checking bench of the gain set switching block
`timescale 1ns/100ps
module test_servo_gain_set_switching import gsw_pkg::*;;
	localparam int P = 4;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic mv = 1'b1, go = 1'b0, ack_o, done, near, fz, rin, set2, busy;
	logic [1:0] mode = MODE_POS;
	logic [15:0] adr_i = 16'h0000, mfg, mfc, st, pg;
	logic [3:0] sel_i = 4'h3;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [15:0] g [5], a [5], b [5], q [$];
	int n_fail = 0, checks_done = 0, seed = 82, n;

	gsw_gain_switch #(.MS_CYCLES_P(P)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .ctrl_mode_i(mode), .positioning_done_i(done),
		.near_i(near), .ref_filter_zero_i(fz), .ref_input_i(rin),
		.speed_loop_gain_o(g[0]), .speed_integral_time_o(g[1]),
		.position_loop_gain_o(g[2]), .torque_filter_time_o(g[3]),
		.friction_comp_gain_o(g[4]), .mf_gain_o(mfg), .mf_corr_o(mfc),
		.speed_loop_structure_o(st), .gain_set2_o(set2), .gain_switching_o(busy));
	gsw_host_model host_u (.clk_i(clk_i), .move_i(mv), .ref_o(rin), .fzero_o(fz),
		.done_o(done), .near_o(near));

	// Clock, 5 ns period
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// Classic Wishbone single cycle, held until ack
	task automatic wb(input logic w, input logic [13:0] idx, input logic [15:0] wd,
		output logic [31:0] r);
		int c;
		c = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {16'h0000, wd};
		do begin
			@(posedge clk_i);
			c++;
		end while (ack_o !== 1'b1 && c < 50);
		chk("ack", ack_o, 1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// Count edges until the set monitor or busy flag reaches v
	task automatic wt(input bit sb, input logic v, output int c);
		c = 0;
		while ((sb ? busy : set2) !== v && c < 500) begin
			@(posedge clk_i);
			c++;
		end
		chk("flag", sb ? busy : set2, v);
	endtask : wt

	// Scoreboard: each position gain change takes the oldest note
	always @(posedge clk_i) begin
		if (go && g[2] !== pg) begin
			chk("pos_gain", g[2], q.size() ? q.pop_front() : 16'hXXXX);
			pg = g[2];
		end
	end

	// Watchdog
	initial begin
		#200000;
		n_fail++;
		summarize();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		pg = g[2];
		go = 1'b1;
		for (int i = 0; i < NREG; i++) begin
			wb(0, REG_IDX[i], 0, rd);
			chk("reg_rst", rd, REG_RST[i]);
		end
		wb(0, 14'h3FFF, 0, rd);
		chk("unmapped", rd, 0);
		for (int j = 0; j < NGAIN; j++) begin
			a[j] = GAINS_RST[j];
			chk("gain_a", g[j], a[j]);
			b[j] = a[j] + 16'h0100 + 16'($random(seed) & 63);
			wb(1, REG_IDX[SL_B + j], b[j], rd);
		end
		wb(1, REG_IDX[SL_WAIT_DN], 16'hFFFF, rd);
		wb(0, REG_IDX[SL_WAIT_DN], 0, rd);
		chk("wait_max", rd, 16'hFFFF);
		wb(1, REG_IDX[SL_WAIT_DN], 1, rd);
		wb(1, REG_IDX[SL_WAIT_UP], 2, rd);
		wb(1, REG_IDX[SL_RAMP_UP], 4, rd);
		wb(1, REG_IDX[SL_RAMP_DN], 0, rd);
		wb(1, REG_IDX[SL_MF_GAIN], 16'h1234, rd);
		wb(1, REG_IDX[SL_MF_CORR], 16'h5678, rd);
		wb(1, REG_IDX[SL_STRUCT], 1, rd);
		wb(1, IDX_CFG, 16'h0002, rd);
		// Set 1 to set 2: wait 2 ms, ramp 4 ms
		for (int k = 1; k < 4; k++)
			q.push_back(16'(a[2] + (b[2] - a[2]) * k / 4));
		q.push_back(b[2]);
		mv <= 1'b0;
		wt(0, 1, n);
		chk("wait_up", n >= 2 * P && n <= 2 * P + 4, 1);
		wt(1, 0, n);
		chk("ramp_up", n >= 4 * P && n <= 4 * P + 4, 1);
		repeat (3) @(posedge clk_i);
		for (int j = 0; j < NGAIN; j++)
			chk("gain_b", g[j], b[j]);
		chk("mf_gain", mfg, 16'h1234);
		chk("mf_corr", mfc, 16'h5678);
		chk("structure", st, 1);
		// Set 2 back to set 1: wait 1 ms, zero ramp
		q.push_back(a[2]);
		mv <= 1'b1;
		wt(0, 0, n);
		chk("wait_dn", n >= P && n <= P + 4, 1);
		wt(1, 0, n);
		repeat (3) @(posedge clk_i);
		for (int j = 0; j < NGAIN; j++)
			chk("gain_a", g[j], a[j]);
		chk("mf_gain_1", mfg, 16'h1234);
		chk("mf_corr_1", mfc, 16'h5678);
		// Fixed sets outside position control, motion random
		for (int c = 0; c < 6; c++) begin
			mode <= c[1] ? MODE_TRQ : MODE_SPD;
			if (c > 0)
				q.push_back(c[0] ? b[2] : a[2]);
			mv <= 1'($random(seed));
			wb(1, IDX_CFG, 16'(c * 16 + 2), rd);
			repeat (4) @(posedge clk_i);
			chk("fixed_set", set2, c[0]);
		end
		// Switching off in position control gives set 1
		wb(1, IDX_CFG, 16'h0010, rd);
		q.push_back(a[2]);
		mode <= MODE_POS;
		repeat (6) @(posedge clk_i);
		chk("auto_off", set2, 0);
		// Reference input as condition A, no ramp up
		mv <= 1'b0;
		wb(1, REG_IDX[SL_RAMP_UP], 0, rd);
		wb(1, IDX_CFG, 16'h0052, rd);
		q.push_back(b[2]);
		mv <= 1'b1;
		wt(0, 1, n);
		chk("wait_ref", n >= 2 * P && n <= 2 * P + 4, 1);
		q.push_back(a[2]);
		mv <= 1'b0;
		wt(0, 0, n);
		chk("wait_ref_dn", n >= P && n <= P + 4, 1);
		wt(1, 0, n);
		chk("mf_keep", mfg, 16'h1234);
		wb(0, IDX_STATUS, 0, rd);
		chk("status", rd, 0);
		chk("notes_left", q.size(), 0);
		summarize();
	end
endmodule : test_servo_gain_set_switching
